// *** pcr_cmd_regs.sv ***
// Command and parameter store behind the power-module management bus
// Operation
// [R1] Byte 0x01 switches output, resets 0x80
// [R2] Byte 0x02 combines pin and command
// [R3] Send 0x03 clears all set fault bits
// [R4] Send 0x11 copies parameters RAM to flash
// [R5] Send 0x12 reloads parameters from flash
// [R6] Master restores only while output is off
// [R7] Read 0x20 returns format byte 0x14
// [R8] Word 0x21 setpoint, 9.6 to 13.2 V
// [R9] Word 0x33 frequency, 120 to 140 kHz
// [R10] Words 0x35/0x36 undervoltage thresholds, 32-46 V
// [R11] Master keeps 2 V undervoltage hysteresis
// [R12] Word 0x40 overvoltage fault limit, kept highest
// [R13] Bytes 0x41/0x47/0x50 fault response selectors
// [R14] Word 0x42 voltage warning below fault limit
// [R15] Word 0x46 overcurrent limit, 20 to 60 A
// [R16] Word 0x4A current warning below fault limit
// [R17] Word 0x4F temperature fault above warning
// [R18] Word 0x51 temperature warning, 25-125 C
// [R19] Word 0x55 input overvoltage, 48-110 V
// [R20] Power good sets at 0x5E level
// [R21] Power good clears at 0x5F level
// [R22] Word 0x60 turn-on delay, 5-500 ms
// [R23] Other words: 5-bit exponent, 11-bit mantissa
// [R24] Voltage words unsigned, exponent fixed -12
// [R25] On/off bit 7 enables, others reserved
// [R26] Read 0x79 returns fault summary word
// [R27] Bad writes rejected and flag communication fault
`default_nettype none
module pcr_cmd_regs
    import pcr_pkg::*;
#(
    parameter bit          POS_LOGIC    = 1'b0,
    parameter int unsigned TON_UNIT_CYC = pcr_pkg::TON_STEP_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Command port from the bus link layer
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    // Answer to the command
    output var  logic        rsp_valid,
    output var  logic        rsp_err,
    output var  logic [15:0] rsp_data,
    // Primary on/off pin, asynchronous
    input  wire logic        on_off_pin,
    // Measurements and fault events from the regulator
    input  wire logic [15:0] vout_meas,
    input  wire logic        vout_ov_evt,
    input  wire logic        iout_oc_evt,
    input  wire logic        vin_uv_evt,
    input  wire logic        temp_evt,
    // Controls toward the power stage
    output var  logic        out_run,
    output var  logic        power_good,
    output var  logic [15:0] vout_target,
    output var  logic [15:0] fsw_word
);
    import pcr_pkg::*;

    localparam int unsigned UW = $clog2(TON_UNIT_CYC + 1);

    // A zero unit would wrap the step counter and never start the output
    if (TON_UNIT_CYC < 1) begin : g_bad_unit
        $error("TON_UNIT_CYC must be at least one");
    end

    typedef struct packed {
        logic [NPAR-1:0][15:0] ram;
        logic [NPAR-1:0][15:0] flash;
        logic [5:1]            fault;
        logic                  pg;
        logic                  pin_s1;
        logic                  pin_s2;
        logic                  run;
        logic [UW-1:0]         unit;
        logic [10:0]           dly;
        logic                  rsp_valid;
        logic                  rsp_err;
        logic [15:0]           rsp_data;
    } pcr_state_s;

    pcr_state_s st;
    pcr_state_s nx;
    pcr_idx_t   idx;
    logic       en;
    logic       pin_on;
    logic [5:1] flt_set;
    logic       flt_clr;
    logic [15:0] status;

    function automatic pcr_idx_t pcr_lookup(input logic [7:0] code);
        pcr_idx_t r;
        r = IDX_NONE;
        for (int i = 0; i < NPAR; i++) begin
            if (PAR_CODE[i] == code) begin
                r = pcr_idx_t'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] pcr_default(input int unsigned i);
        logic [15:0] r;
        r = PAR_DEF[i];
        if (POS_LOGIC && i == int'(IDX_ONOFF)) begin
            r = ONOFF_POS_DEF;
        end
        return r;
    endfunction

    // Range check plus the ordering between limits that belong together
    function automatic logic pcr_write_ok(input pcr_idx_t i, input logic [15:0] w,
                                          input logic [NPAR-1:0][15:0] ram);
        logic ok;
        ok = (w >= PAR_MIN[i]) && (w <= PAR_MAX[i]); // R8 R9 R10 R15 R18 R19 R22 R27
        if (PAR_L11[i]) begin // R23
            ok = ok && (w[15:11] == PAR_MIN[i][15:11]); // R23
        end
        unique case (i)
            IDX_OVF:  ok = ok && (w >= ram[IDX_VOUT]) && (w >= ram[IDX_OVW]); // R12
            IDX_OVW:  ok = ok && (w <= ram[IDX_OVF]); // R14
            IDX_VOUT: ok = ok && (w <= ram[IDX_OVF]); // R12
            IDX_OCF:  ok = ok && (w >= ram[IDX_OCW]); // R16
            IDX_OCW:  ok = ok && (w <= ram[IDX_OCF]); // R16
            IDX_OTF:  ok = ok && (w >= ram[IDX_OTW]); // R17
            IDX_OTW:  ok = ok && (w <= ram[IDX_OTF]); // R17
            default:  ok = ok;
        endcase
        return ok;
    endfunction

    always_comb begin
        nx = st;
        idx = pcr_lookup(cmd_code);
        flt_clr = 1'b0;
        flt_set = '0;
        nx.pin_s1 = on_off_pin;
        nx.pin_s2 = st.pin_s1;
        nx.rsp_valid = 1'b0;
        nx.rsp_err = 1'b0;

        status = '0;
        status[5:1] = st.fault;
        status[SW_OFF] = ~st.run;
        status[SW_PG] = st.pg;

        if (cmd_valid) begin
            nx.rsp_valid = 1'b1;
            if (cmd_write) begin
                if (cmd_code == CMD_CLEAR) begin
                    flt_clr = 1'b1; // R3
                end else if (cmd_code == CMD_STORE) begin
                    nx.flash = st.ram; // R4
                end else if (cmd_code == CMD_RESTORE && !st.run) begin
                    nx.ram = st.flash; // R5
                end else if (idx != IDX_NONE && pcr_write_ok(idx, cmd_wdata, st.ram)) begin
                    nx.ram[idx] = cmd_wdata & PAR_MASK[idx]; // R1 R2 R13 R25
                end else begin
                    // A restore while running is refused rather than glitching the loop
                    nx.rsp_err = 1'b1; // R6 R27
                end
            end else begin
                if (idx != IDX_NONE) begin
                    nx.rsp_data = st.ram[idx];
                end else if (cmd_code == CMD_VOUT_MODE) begin
                    nx.rsp_data = VOUT_MODE_VAL; // R7
                end else if (cmd_code == CMD_STATUS) begin
                    nx.rsp_data = status; // R26
                end else begin
                    nx.rsp_data = '0;
                    nx.rsp_err = 1'b1; // R27
                end
            end
        end

        // Events win over a clear arriving in the same cycle
        flt_set[SW_VOV] = vout_ov_evt;
        flt_set[SW_IOC] = iout_oc_evt;
        flt_set[SW_VUV] = vin_uv_evt;
        flt_set[SW_OT] = temp_evt;
        flt_set[SW_CML] = nx.rsp_err; // R27
        nx.fault = (flt_clr ? 5'h00 : st.fault) | flt_set; // R3

        // On threshold wins if both limits are met at once
        if (vout_meas >= st.ram[IDX_PGON]) begin
            nx.pg = 1'b1; // R20
        end else if (vout_meas <= st.ram[IDX_PGOFF]) begin
            nx.pg = 1'b0; // R21
        end

        pin_on = st.ram[IDX_ONOFF][CFG_POL] ? st.pin_s2 : ~st.pin_s2;
        en = ~st.ram[IDX_ONOFF][CFG_USE]
             | ((~st.ram[IDX_ONOFF][CFG_CMD] | st.ram[IDX_OP][OP_EN])
                & (~st.ram[IDX_ONOFF][CFG_PIN] | pin_on)); // R2 R25

        if (!en) begin
            nx.run = 1'b0;
            nx.unit = '0;
            nx.dly = '0;
        end else if (!st.run) begin
            if (st.dly >= st.ram[IDX_TON][10:0]) begin
                nx.run = 1'b1; // R22
            end else if (st.unit == UW'(TON_UNIT_CYC - 1)) begin
                nx.unit = '0;
                nx.dly = st.dly + 11'd1;
            end else begin
                nx.unit = st.unit + UW'(1);
            end
        end

        if (srst) begin
            nx = '0;
            for (int i = 0; i < NPAR; i++) begin
                nx.ram[i] = pcr_default(i); // R1 R2
                nx.flash[i] = pcr_default(i);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        st <= nx;
    end

    assign rsp_valid   = st.rsp_valid;
    assign rsp_err     = st.rsp_err;
    assign rsp_data    = st.rsp_data;
    assign out_run     = st.run;
    assign power_good  = st.pg;
    assign vout_target = st.ram[IDX_VOUT];
    assign fsw_word    = st.ram[3];

    sequence s_read(logic [7:0] code);
        cmd_valid && !cmd_write && cmd_code == code;
    endsequence

    sequence s_send(logic [7:0] code);
        cmd_valid && cmd_write && cmd_code == code;
    endsequence

    a_clear_faults: assert property (@(posedge core_clk) disable iff (srst) // R3
        s_send(CMD_CLEAR) && !vout_ov_evt && !iout_oc_evt && !vin_uv_evt && !temp_evt
        |=> st.fault == 5'h00)
        else $error("faults not cleared");

    a_store_copy: assert property (@(posedge core_clk) disable iff (srst) // R4
        s_send(CMD_STORE) |=> st.flash == $past(st.ram) && !rsp_err)
        else $error("store did not copy working values");

    a_restore_load: assert property (@(posedge core_clk) disable iff (srst) // R5
        s_send(CMD_RESTORE) && !st.run |=> st.ram == $past(st.flash) && !rsp_err)
        else $error("restore did not reload working values");

    a_mode_read: assert property (@(posedge core_clk) disable iff (srst) // R7
        s_read(CMD_VOUT_MODE) |=> rsp_valid && rsp_data == 16'h0014)
        else $error("format byte wrong");

    a_range_reject: assert property (@(posedge core_clk) disable iff (srst) // R27
        cmd_valid && cmd_write && cmd_code == 8'h21 && cmd_wdata > 16'hd333
        |=> rsp_err && vout_target == $past(vout_target) && st.fault[SW_CML])
        else $error("out of range write accepted");

    a_pg_set: assert property (@(posedge core_clk) disable iff (srst) // R20
        vout_meas >= st.ram[IDX_PGON] |=> power_good)
        else $error("power good not set");

    a_pg_clear: assert property (@(posedge core_clk) disable iff (srst) // R21
        vout_meas < st.ram[IDX_PGON] && vout_meas <= st.ram[IDX_PGOFF] |=> !power_good)
        else $error("power good not cleared");

    a_op_reserved: assert property (@(posedge core_clk) disable iff (srst) // R25
        st.ram[IDX_OP][6:0] == 7'h00)
        else $error("reserved on/off bits set");

    a_status_pg: assert property (@(posedge core_clk) disable iff (srst) // R26
        s_read(CMD_STATUS) |=> rsp_data[SW_PG] == $past(power_good)
        && rsp_data[SW_OFF] == !$past(out_run))
        else $error("status word wrong");

    a_run_drop: assert property (@(posedge core_clk) disable iff (srst) // R1
        out_run && !en |=> !out_run)
        else $error("output not switched off");

    sequence s_read_par;
        cmd_valid && !cmd_write && idx != IDX_NONE;
    endsequence

    sequence s_write_par;
        cmd_valid && cmd_write && idx != IDX_NONE;
    endsequence

    // Codes that are neither a stored parameter nor a send-byte action
    sequence s_write_other;
        cmd_valid && cmd_write && idx == IDX_NONE && cmd_code != CMD_CLEAR
        && cmd_code != CMD_STORE && cmd_code != CMD_RESTORE;
    endsequence

    a_answer_once: assert property (@(posedge core_clk) disable iff (srst) // R27
        rsp_valid == ($past(cmd_valid) && !$past(srst)))
        else $error("answer pulse wrong");

    a_read_back: assert property (@(posedge core_clk) disable iff (srst) // R1 R13
        s_read_par |=> rsp_data == $past(st.ram[idx]) && !rsp_err)
        else $error("stored value not read back");

    a_write_masked: assert property (@(posedge core_clk) disable iff (srst) // R25
        s_write_par |=> (st.ram[$past(idx)] & ~PAR_MASK[$past(idx)]) == 16'h0000)
        else $error("reserved bits stored");

    a_write_kept: assert property (@(posedge core_clk) disable iff (srst) // R27
        s_write_par ##1 rsp_err |-> st.ram == $past(st.ram))
        else $error("refused write changed the store");

    a_unknown_reject: assert property (@(posedge core_clk) disable iff (srst) // R27
        s_write_other |=> rsp_err && st.fault[SW_CML])
        else $error("write to unknown code accepted");

    a_restore_refused: assert property (@(posedge core_clk) disable iff (srst) // R5 R27
        s_send(CMD_RESTORE) && st.run |=> rsp_err && st.ram == $past(st.ram))
        else $error("restore taken while running");

    a_op_write: assert property (@(posedge core_clk) disable iff (srst) // R1 R25
        s_send(8'h01) && cmd_wdata[15:8] == 8'h00
        |=> st.ram[IDX_OP] == {8'h00, $past(cmd_wdata[OP_EN]), 7'h00})
        else $error("on/off byte not stored");

    // Events land even when a clear is taken in the same cycle
    a_event_wins: assert property (@(posedge core_clk) disable iff (srst) // R3 R26
        (vout_ov_evt || iout_oc_evt || vin_uv_evt || temp_evt)
        |=> (st.fault[5:2] & $past({vout_ov_evt, iout_oc_evt, vin_uv_evt, temp_evt}))
            == $past({vout_ov_evt, iout_oc_evt, vin_uv_evt, temp_evt}))
        else $error("fault event lost");

    a_pg_hold: assert property (@(posedge core_clk) disable iff (srst) // R20 R21
        vout_meas < st.ram[IDX_PGON] && vout_meas > st.ram[IDX_PGOFF]
        |=> power_good == $past(power_good))
        else $error("power good moved inside the band");

    // Output starts only once the whole delay has been counted
    a_run_delay: assert property (@(posedge core_clk) disable iff (srst) // R22
        $rose(out_run) |-> en && st.dly >= st.ram[IDX_TON][10:0])
        else $error("output started early");
endmodule
`default_nettype wire

// *** pcr_mst.sv ***
// Bus master model that issues commands to the parameter store
`default_nettype none
module pcr_mst (
    // Clock
    input  wire logic        core_clk,
    // Command toward the store
    output var  logic        cmd_valid,
    output var  logic        cmd_write,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_wdata,
    // Answer from the store
    input  wire logic        rsp_valid,
    input  wire logic        rsp_err,
    input  wire logic [15:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Lines are inverted once released so a stale value can never pass as valid
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                        output logic v, output logic e, output logic [15:0] q);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge core_clk);
        v = rsp_valid;
        e = rsp_err;
        q = rsp_data;
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_code  = ~c;
        cmd_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// *** pcr_pkg.sv ***
// Constants for the power-module command and parameter store
`default_nettype none
package pcr_pkg;
    // Parameter table layout
    localparam int unsigned NPAR = 19;
    typedef logic [4:0] pcr_idx_t;
    localparam pcr_idx_t IDX_NONE  = 5'h1f;
    localparam pcr_idx_t IDX_OP    = 5'h00;
    localparam pcr_idx_t IDX_ONOFF = 5'h01;
    localparam pcr_idx_t IDX_VOUT  = 5'h02;
    localparam pcr_idx_t IDX_OVF   = 5'h06;
    localparam pcr_idx_t IDX_OVW   = 5'h08;
    localparam pcr_idx_t IDX_OCF   = 5'h09;
    localparam pcr_idx_t IDX_OCW   = 5'h0b;
    localparam pcr_idx_t IDX_OTF   = 5'h0c;
    localparam pcr_idx_t IDX_OTW   = 5'h0e;
    localparam pcr_idx_t IDX_PGON  = 5'h10;
    localparam pcr_idx_t IDX_PGOFF = 5'h11;
    localparam pcr_idx_t IDX_TON   = 5'h12;

    // Command codes of the stored parameters, in table order
    localparam logic [7:0] PAR_CODE [NPAR] = '{8'h01, 8'h02, 8'h21, 8'h33, 8'h35, 8'h36,
        8'h40, 8'h41, 8'h42, 8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h5e,
        8'h5f, 8'h60};
    // Values after reset, encoded as they are read back
    localparam logic [15:0] PAR_DEF [NPAR] = '{16'h0080, 16'h001d, 16'hc000, 16'hf208,
        16'he910, 16'he900, 16'hf000, 16'h00b8, 16'hf000, 16'he2b0, 16'h00f8, 16'he240,
        16'hf1f4, 16'h00b8, 16'hf1cc, 16'heb70, 16'hb000, 16'h9000, 16'hf80e};
    localparam logic [15:0] PAR_MIN [NPAR] = '{16'h0000, 16'h0000, 16'h999a, 16'hf1e0,
        16'he900, 16'he900, 16'hb000, 16'h0000, 16'hb000, 16'he140, 16'h0000, 16'he0a0,
        16'hf064, 16'h0000, 16'hf064, 16'he980, 16'h819a, 16'h819a, 16'hf80a};
    localparam logic [15:0] PAR_MAX [NPAR] = '{16'h00ff, 16'h00ff, 16'hd333, 16'hf230,
        16'he970, 16'he970, 16'hffff, 16'h00ff, 16'hffff, 16'he3c0, 16'h00ff, 16'he280,
        16'hf230, 16'h00ff, 16'hf1f4, 16'heb70, 16'hd333, 16'hd333, 16'hfbe8};
    // Writable bits; the rest read as zero
    localparam logic [15:0] PAR_MASK [NPAR] = '{16'h0080, 16'h001f, 16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'h00ff, 16'hffff,
        16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
    // Entries with a fixed exponent in bits 15:11
    localparam logic [NPAR-1:0] PAR_L11 = 19'h4da38;
    localparam logic [15:0] ONOFF_POS_DEF = 16'h001f;

    // Send-byte and read-only codes
    localparam logic [7:0] CMD_CLEAR     = 8'h03;
    localparam logic [7:0] CMD_STORE     = 8'h11;
    localparam logic [7:0] CMD_RESTORE   = 8'h12;
    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
    localparam logic [7:0] CMD_STATUS    = 8'h79;
    localparam logic [15:0] VOUT_MODE_VAL = 16'h0014;

    // Field positions
    localparam int unsigned OP_EN   = 7;
    localparam int unsigned CFG_USE = 4;
    localparam int unsigned CFG_CMD = 3;
    localparam int unsigned CFG_PIN = 2;
    localparam int unsigned CFG_POL = 1;
    localparam int unsigned SW_OFF  = 6;
    localparam int unsigned SW_VOV  = 5;
    localparam int unsigned SW_IOC  = 4;
    localparam int unsigned SW_VUV  = 3;
    localparam int unsigned SW_OT   = 2;
    localparam int unsigned SW_CML  = 1;
    localparam int unsigned SW_PG   = 11;

    // Turn-on delay step and clock
    localparam int unsigned TON_STEP_NS  = 500000;
    localparam int unsigned CLK_NS       = 20;
    localparam int unsigned TON_STEP_CYC = TON_STEP_NS / CLK_NS;
endpackage
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the command and parameter store
`default_nettype none
module tb;
    import pcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, on_off_pin = 1'b1;
    logic cmd_valid, cmd_write, rsp_valid, rsp_err, out_run, power_good;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_data, vout_target, fsw_word, vout_meas = 16'h0;
    logic [3:0] evt = 4'h0;
    logic [15:0] mr [NPAR], mf [NPAR], st = 16'h0;
    logic run = 1'b0, pg = 1'b0;
    int errors = 0, n_checks = 0, seed = 32'hc079, r, k;
    logic [7:0] wc [19] = '{8'h21, 8'h21, 8'h21, 8'h21, 8'h60, 8'h60, 8'h60, 8'h01, 8'h02,
        8'h35, 8'h36, 8'h40, 8'h42, 8'h46, 8'h4a, 8'h51, 8'h4f, 8'h20, 8'h99};
    logic [15:0] wd [19] = '{16'h999a, 16'h9999, 16'hd334, 16'hc000, 16'hf80a, 16'hf809,
        16'hfbe9, 16'h00ff, 16'h001c, 16'he920, 16'he910, 16'hb000, 16'hf800, 16'he140,
        16'he0a0, 16'hf1f4, 16'hf064, 16'h0000, 16'h1234};
    logic [7:0] rc [8] = '{8'h33, 8'h35, 8'h36, 8'h46, 8'h4a, 8'h4f, 8'h51, 8'h55};

    always #10 core_clk = ~core_clk;

    pcr_cmd_regs #(.POS_LOGIC(1'b0), .TON_UNIT_CYC(4)) dut (
        .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_data(rsp_data), .on_off_pin(on_off_pin),
        .vout_meas(vout_meas), .vout_ov_evt(evt[3]), .iout_oc_evt(evt[2]),
        .vin_uv_evt(evt[1]), .temp_evt(evt[0]), .out_run(out_run),
        .power_good(power_good), .vout_target(vout_target), .fsw_word(fsw_word));
    pcr_mst mst (
        .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_data(rsp_data));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic int fidx(logic [7:0] c);
        foreach (PAR_CODE[i]) if (PAR_CODE[i] == c) return i;
        return -1;
    endfunction

    // Reference write: returns 1 when the store must refuse
    function automatic logic mwr(logic [7:0] c, logic [15:0] d);
        int i = fidx(c);
        if (c == CMD_CLEAR) begin
            st = 16'h0;
            return 1'b0;
        end
        if (c == CMD_STORE) begin
            mf = mr;
            return 1'b0;
        end
        if (c == CMD_RESTORE) begin
            if (run) return 1'b1;
            mr = mf;
            return 1'b0;
        end
        if (i < 0 || d < PAR_MIN[i] || d > PAR_MAX[i]) return 1'b1;
        if ((c == 8'h40 && (d < mr[IDX_VOUT] || d < mr[IDX_OVW])) ||
            ((c == 8'h42 || c == 8'h21) && d > mr[IDX_OVF]) ||
            (c == 8'h46 && d < mr[IDX_OCW]) || (c == 8'h4a && d > mr[IDX_OCF]) ||
            (c == 8'h4f && d < mr[IDX_OTW]) || (c == 8'h51 && d > mr[IDX_OTF])) return 1'b1;
        mr[i] = d & PAR_MASK[i];
        return 1'b0;
    endfunction

    task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] d);
        logic v, e, ee;
        logic [15:0] q, eq;
        eq = 16'h0;
        ee = 1'b0;
        if (wr) ee = mwr(c, d);
        else if (c == CMD_VOUT_MODE) eq = VOUT_MODE_VAL;
        else if (c == CMD_STATUS) eq = st | {4'h0, pg, 4'h0, !run, 6'h0};
        else if (fidx(c) < 0) ee = 1'b1;
        else eq = mr[fidx(c)];
        mst.xfer(wr, c, d, v, e, q);
        check({15'h0, v}, 16'h1);
        check({15'h0, e}, {15'h0, ee});
        if (!wr) check(q, eq);
        if (ee) st[SW_CML] = 1'b1;
    endtask

    initial begin
        for (int i = 0; i < NPAR; i++) mr[i] = PAR_DEF[i];
        mf = mr;
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        foreach (PAR_CODE[i]) cmd(1'b0, PAR_CODE[i], 16'h0);
        cmd(1'b0, CMD_VOUT_MODE, 16'h0);
        cmd(1'b0, 8'h99, 16'h0);
        cmd(1'b0, CMD_STATUS, 16'h0);
        // Keeps the 2 V undervoltage hysteresis when thresholds are moved
        foreach (wc[i]) begin
            cmd(1'b1, wc[i], wd[i]);
            if (fidx(wc[i]) >= 0) cmd(1'b0, wc[i], 16'h0);
        end
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            k = fidx(rc[r[2:0]]);
            r = (r >>> 3) & 32'hffff;
            r = int'(PAR_MIN[k]) - 4 + r % (int'(PAR_MAX[k]) - int'(PAR_MIN[k]) + 9);
            cmd(1'b1, PAR_CODE[k], r[15:0]);
        end
        foreach (rc[i]) cmd(1'b0, rc[i], 16'h0);
        check(vout_target, mr[IDX_VOUT]);
        check(fsw_word, mr[fidx(8'h33)]);
        for (int b = 0; b < 4; b++) begin
            @(negedge core_clk) evt = 4'h1 << b;
            @(negedge core_clk) evt = 4'h0;
            st[SW_OT + b] = 1'b1;
        end
        cmd(1'b0, CMD_STATUS, 16'h0);
        cmd(1'b1, CMD_CLEAR, 16'h0);
        cmd(1'b0, CMD_STATUS, 16'h0);
        cmd(1'b1, CMD_STORE, 16'h0);
        cmd(1'b1, 8'h21, 16'hb800);
        cmd(1'b1, CMD_RESTORE, 16'h0);
        cmd(1'b0, 8'h21, 16'h0);
        vout_meas = 16'hb000;
        repeat (3) @(negedge core_clk);
        pg = 1'b1;
        check({15'h0, power_good}, 16'h1);
        vout_meas = 16'h9001;
        repeat (3) @(negedge core_clk);
        cmd(1'b0, CMD_STATUS, 16'h0);
        vout_meas = 16'h9000;
        repeat (3) @(negedge core_clk);
        pg = 1'b0;
        check({15'h0, power_good}, 16'h0);
        on_off_pin = 1'b0;
        k = int'(mr[IDX_TON][10:0]) * 4;
        // Two synchroniser edges and the counted steps, then one edge to start
        repeat (k + 2) @(negedge core_clk);
        check({15'h0, out_run}, 16'h0);
        @(negedge core_clk);
        run = 1'b1;
        check({15'h0, out_run}, 16'h1);
        // Restore while running is sent on purpose to see it refused
        cmd(1'b1, CMD_RESTORE, 16'h0);
        cmd(1'b0, CMD_STATUS, 16'h0);
        cmd(1'b1, 8'h01, 16'h0000);
        run = 1'b0;
        repeat (2) @(negedge core_clk);
        check({15'h0, out_run}, 16'h0);
        // Pin made active high and the on/off byte ignored: the pin alone starts it
        cmd(1'b1, 8'h02, 16'h0016);
        on_off_pin = 1'b1;
        repeat (k + 2) @(negedge core_clk);
        check({15'h0, out_run}, 16'h0);
        @(negedge core_clk);
        check({15'h0, out_run}, 16'h1);
        give_verdict();
    end

    initial begin
        // About thirty times the length of a clean run
        #200000;
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
